// *** bio_assertions.sv ***
// Checker for the backplane handshake between the computer end and the card.
`timescale 1ns/1ps
module bio_assertions #(
  parameter int DW = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [DW-1:0] io_bus_cpu_o,
  input wire logic io_bus_cpu_oe,
  input wire logic [DW-1:0] io_bus_card_o,
  input wire logic io_bus_card_oe,
  input wire logic [DW-1:0] io_bus_i,
  input wire logic set_control_instruction,
  input wire logic clear_control,
  input wire logic block_strobe_qualifier,
  input wire logic block_input_strobe,
  input wire logic block_output_strobe,
  input wire logic skip_on_flag_line
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [3:0] since_q_ff;
  // Counts cycles since the last qualifier, saturating.
  always_ff @(posedge aclk) begin
    if (!aresetn || block_strobe_qualifier) begin
      since_q_ff <= 4'h0;
    end else if (since_q_ff != 4'hf) begin
      since_q_ff <= since_q_ff + 4'h1;
    end
  end
  property p_in_qual;
    block_input_strobe |-> block_strobe_qualifier && !block_output_strobe;
  endproperty
  a_in_qual: assert property (p_in_qual) else $error("input strobe without qualifier");
  property p_out_frame;
    $rose(io_bus_cpu_oe) |=> block_strobe_qualifier && block_output_strobe
      ##1 io_bus_cpu_oe && block_output_strobe && !block_strobe_qualifier ##1 !io_bus_cpu_oe && !block_output_strobe;
  endproperty
  a_out_frame: assert property (p_out_frame) else $error("output frame timing wrong");
  property p_out_data;
    block_output_strobe |-> io_bus_cpu_oe && !block_input_strobe && io_bus_i == io_bus_cpu_o;
  endproperty
  a_out_data: assert property (p_out_data) else $error("output strobe without data");
  property p_card_release;
    io_bus_card_oe |-> block_input_strobe && block_strobe_qualifier;
  endproperty
  a_card_release: assert property (p_card_release) else $error("card drives bus unasked");
  property p_card_drive;
    io_bus_card_oe |-> !io_bus_cpu_oe && io_bus_i == io_bus_card_o;
  endproperty
  a_card_drive: assert property (p_card_drive) else $error("card word not on bus");
  property p_qual_space;
    block_strobe_qualifier |=> !block_strobe_qualifier [*5];
  endproperty
  a_qual_space: assert property (p_qual_space) else $error("qualifiers too close");
  property p_set_pulse;
    set_control_instruction |-> !clear_control ##1 !set_control_instruction;
  endproperty
  a_set_pulse: assert property (p_set_pulse) else $error("set control not a clean pulse");
  property p_launch;
    block_strobe_qualifier |-> $past(skip_on_flag_line, 4);
  endproperty
  a_launch: assert property (p_launch) else $error("transfer launched without flag");
  property p_flag_drop;
    $fell(skip_on_flag_line) |-> since_q_ff <= 4'h5;
  endproperty
  a_flag_drop: assert property (p_flag_drop) else $error("flag dropped without strobe");
endmodule : bio_assertions

// *** bio_bus_if.sv ***
// Backplane signals between the computer I/O section and the interface card.
`timescale 1ns/1ps
interface bio_bus_if #(parameter int DW = 16);
  logic [DW-1:0] io_bus_cpu_o;
  logic io_bus_cpu_oe;
  logic [DW-1:0] io_bus_card_o;
  logic io_bus_card_oe;
  logic [DW-1:0] io_bus_i;
  logic set_control_instruction;
  logic clear_control;
  logic block_strobe_qualifier;
  logic block_input_strobe;
  logic block_output_strobe;
  logic skip_on_flag_line;
  assign io_bus_i = (io_bus_cpu_oe ? io_bus_cpu_o : '0) | (io_bus_card_oe ? io_bus_card_o : '0);
  modport cpu (
    output io_bus_cpu_o, io_bus_cpu_oe, set_control_instruction, clear_control,
    output block_strobe_qualifier, block_input_strobe, block_output_strobe,
    input io_bus_i, skip_on_flag_line
  );
  modport card (
    output io_bus_card_o, io_bus_card_oe, skip_on_flag_line,
    input io_bus_i, set_control_instruction, clear_control,
    input block_strobe_qualifier, block_input_strobe, block_output_strobe
  );
endinterface : bio_bus_if

// *** bio_card.sv ***
// Interface card: flag, synchroniser, control flip-flop and data buffers.
`timescale 1ns/1ps
module bio_card import bio_pkg::*; #(
  parameter int DW = BIO_DW,
  parameter bit OUTPUT_CARD = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  bio_bus_if.card bus,
  input wire logic periph_ready,
  input wire logic [DW-1:0] periph_data_in,
  output logic periph_start,
  output logic [DW-1:0] periph_data_out,
  output logic control_active
);
  logic ctl_ff;
  logic flag_ff;
  logic sync1_ff;
  logic sync2_ff;
  logic start_ff;
  logic [DW-1:0] in_buf_ff;
  logic [DW-1:0] out_buf_ff;
  logic addressed;
  logic in_stb;
  logic out_stb;

  assign addressed = ctl_ff & bus.block_strobe_qualifier;
  assign in_stb = addressed & bus.block_input_strobe;
  assign out_stb = addressed & bus.block_output_strobe;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_ff <= 1'b0;
    end else if (bus.set_control_instruction) begin
      ctl_ff <= 1'b1;
    end else if (bus.clear_control) begin
      ctl_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_ff <= OUTPUT_CARD;
    end else if (periph_ready) begin
      flag_ff <= 1'b1;
    end else if (OUTPUT_CARD ? out_stb : in_stb) begin
      flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= flag_ff;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_buf_ff <= '0;
    end else if (periph_ready && !OUTPUT_CARD) begin
      in_buf_ff <= periph_data_in;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_buf_ff <= '0;
    end else if (out_stb && OUTPUT_CARD) begin
      out_buf_ff <= bus.io_bus_i;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_ff <= 1'b0;
    end else begin
      start_ff <= OUTPUT_CARD ? out_stb : in_stb;
    end
  end

  assign bus.skip_on_flag_line = sync2_ff;
  assign bus.io_bus_card_oe = in_stb & !OUTPUT_CARD;
  assign bus.io_bus_card_o = in_buf_ff;
  assign periph_start = start_ff;
  assign periph_data_out = out_buf_ff;
  assign control_active = ctl_ff;
endmodule : bio_card

// *** bio_cpu.sv ***
// Computer end: AXI4-Lite registers, T-period sequencer and block transfer engine.
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module bio_cpu import bio_pkg::*; #(
  parameter int DW = BIO_DW,
  parameter int DEPTH = BIO_MAX_WORDS,
  parameter int HANG_CYCLES = BIO_HANG_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  bio_bus_if.cpu bus,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic emergency_interrupt_condition,
  input wire logic dma_freeze,
  output logic interrupts_enabled
);
  logic [DW-1:0] mem [DEPTH];
  bio_state_t state_ff;
  bio_state_t nxt_state;
  logic [2:0] phase_ff;
  logic [BIO_CW-1:0] count_ff;
  logic [BIO_AW-1:0] buf_addr_ff;
  logic [BIO_AW-1:0] mem_addr_ff;
  logic [DW-1:0] scratch_ff;
  logic dir_out_ff;
  logic done_ff;
  logic aborted_ff;
  logic ien_ff;
  logic setctl_ff;
  logic clrctl_ff;
  logic [31:0] hang_ff;
  logic aw_have_ff;
  logic w_have_ff;
  logic [5:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_go;
  logic wr_ctrl;
  logic start_req;
  logic abort_req;
  logic hang;

  function automatic logic known_reg(input logic [5:0] a);
    known_reg = (a == BIO_REG_CTRL) || (a == BIO_REG_STATUS) || (a == BIO_REG_COUNT) ||
                (a == BIO_REG_BUFADDR) || (a == BIO_REG_MEMADDR) || (a == BIO_REG_MEMDATA);
  endfunction : known_reg

  assign s_axi_awready = !aw_have_ff && !bvalid_ff;
  assign s_axi_wready = !w_have_ff && !bvalid_ff;
  assign wr_go = aw_have_ff && w_have_ff && !bvalid_ff;
  assign wr_ctrl = wr_go && (aw_addr_ff == BIO_REG_CTRL);
  assign start_req = wr_ctrl && w_data_ff[BIO_CTRL_START] && (state_ff == BIO_IDLE);
  assign abort_req = wr_ctrl && w_data_ff[BIO_CTRL_ABORT];
  assign hang = (hang_ff >= 32'(HANG_CYCLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      aw_addr_ff <= 6'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_ff <= 1'b1;
      aw_addr_ff <= {s_axi_awaddr[5:2], 2'h0};
    end else if (wr_go) begin
      aw_have_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_ff <= 1'b0;
      w_data_ff <= 32'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_ff <= 1'b1;
      w_data_ff <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    end else if (wr_go) begin
      w_have_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= BIO_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= known_reg(aw_addr_ff) ? BIO_RESP_OKAY : BIO_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_arready = !rvalid_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= BIO_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= known_reg({s_axi_araddr[5:2], 2'h0}) ? BIO_RESP_OKAY : BIO_RESP_SLVERR;
      unique case ({s_axi_araddr[5:2], 2'h0})
        BIO_REG_CTRL: rdata_ff <= 32'({dir_out_ff, 1'b0});
        BIO_REG_STATUS: rdata_ff <= 32'({bus.skip_on_flag_line, ien_ff, aborted_ff, done_ff, state_ff != BIO_IDLE});
        BIO_REG_COUNT: rdata_ff <= 32'(count_ff);
        BIO_REG_BUFADDR: rdata_ff <= 32'(buf_addr_ff);
        BIO_REG_MEMADDR: rdata_ff <= 32'(mem_addr_ff);
        BIO_REG_MEMDATA: rdata_ff <= 32'(mem[mem_addr_ff]);
        default: rdata_ff <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setctl_ff <= 1'b0;
      clrctl_ff <= 1'b0;
      dir_out_ff <= 1'b0;
      mem_addr_ff <= '0;
    end else begin
      setctl_ff <= wr_ctrl && w_data_ff[BIO_CTRL_SETCTL];
      clrctl_ff <= wr_ctrl && w_data_ff[BIO_CTRL_CLRCTL];
      if (wr_ctrl && state_ff == BIO_IDLE) begin
        dir_out_ff <= w_data_ff[BIO_CTRL_DIR];
      end
      if (wr_go && aw_addr_ff == BIO_REG_MEMADDR) begin
        mem_addr_ff <= w_data_ff[BIO_AW-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_ff <= BIO_T1;
    end else begin
      phase_ff <= (phase_ff == BIO_T6) ? BIO_T1 : phase_ff + 3'h1;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      BIO_IDLE: if (start_req) nxt_state = (count_ff == '0) ? BIO_DONE : BIO_TEST;
      BIO_TEST: begin
        if (emergency_interrupt_condition || abort_req || hang) begin
          nxt_state = BIO_ABORT;
        end else if (bus.skip_on_flag_line && phase_ff == BIO_T6 && !dma_freeze) begin
          nxt_state = BIO_XFER;
        end
      end
      BIO_XFER: if (phase_ff == BIO_T6) nxt_state = dir_out_ff ? BIO_NEXT : BIO_STORE;
      BIO_STORE: nxt_state = BIO_NEXT;
      BIO_NEXT: nxt_state = (count_ff == 9'h001) ? BIO_DONE : BIO_TEST;
      BIO_DONE: nxt_state = BIO_IDLE;
      BIO_ABORT: nxt_state = BIO_IDLE;
      default: nxt_state = BIO_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= BIO_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_ff <= '0;
      buf_addr_ff <= '0;
    end else if (state_ff == BIO_NEXT) begin
      count_ff <= count_ff - 9'h001;
      buf_addr_ff <= buf_addr_ff + 8'h01;
    end else if (wr_go && state_ff == BIO_IDLE && aw_addr_ff == BIO_REG_COUNT) begin
      count_ff <= (w_data_ff > 32'(BIO_MAX_WORDS)) ? 9'(BIO_MAX_WORDS) : w_data_ff[BIO_CW-1:0];
    end else if (wr_go && state_ff == BIO_IDLE && aw_addr_ff == BIO_REG_BUFADDR) begin
      buf_addr_ff <= w_data_ff[BIO_AW-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scratch_ff <= '0;
    end else if (state_ff == BIO_TEST && nxt_state == BIO_XFER && dir_out_ff) begin
      scratch_ff <= mem[buf_addr_ff];
    end else if (state_ff == BIO_XFER && phase_ff == BIO_T4 && !dir_out_ff) begin
      scratch_ff <= bus.io_bus_i;
    end
  end

  always_ff @(posedge aclk) begin
    if (state_ff == BIO_STORE) begin
      mem[buf_addr_ff] <= scratch_ff;
    end else if (wr_go && aw_addr_ff == BIO_REG_MEMDATA && state_ff == BIO_IDLE) begin
      mem[mem_addr_ff] <= w_data_ff[DW-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hang_ff <= 32'h0;
    end else if (state_ff == BIO_TEST) begin
      hang_ff <= hang_ff + 32'h1;
    end else begin
      hang_ff <= 32'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ien_ff <= 1'b1;
      done_ff <= 1'b0;
      aborted_ff <= 1'b0;
    end else if (start_req) begin
      ien_ff <= 1'b0;
      done_ff <= 1'b0;
      aborted_ff <= 1'b0;
    end else if (state_ff == BIO_DONE) begin
      ien_ff <= 1'b1;
      done_ff <= 1'b1;
    end else if (state_ff == BIO_ABORT) begin
      ien_ff <= 1'b1;
      aborted_ff <= 1'b1;
    end
  end

  assign bus.set_control_instruction = setctl_ff;
  assign bus.clear_control = clrctl_ff;
  assign bus.block_strobe_qualifier = (state_ff == BIO_XFER) && (phase_ff == BIO_T4);
  assign bus.block_input_strobe = (state_ff == BIO_XFER) && !dir_out_ff && (phase_ff == BIO_T4);
  assign bus.block_output_strobe = (state_ff == BIO_XFER) && dir_out_ff &&
                                   (phase_ff == BIO_T4 || phase_ff == BIO_T5);
  assign bus.io_bus_cpu_oe = (state_ff == BIO_XFER) && dir_out_ff &&
                             (phase_ff >= BIO_T3) && (phase_ff <= BIO_T5);
  assign bus.io_bus_cpu_o = scratch_ff;
  assign interrupts_enabled = ien_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
endmodule : bio_cpu

// *** bio_pkg.sv ***
// Constants, register map and state encoding for the block transfer pair.
package bio_pkg;
  localparam int BIO_DW = 16;
  localparam int BIO_MAX_WORDS = 256;
  localparam int BIO_CW = 9;
  localparam int BIO_AW = 8;
  localparam int BIO_HANG_CYCLES = 100000;
  localparam logic [2:0] BIO_T1 = 3'h0;
  localparam logic [2:0] BIO_T3 = 3'h2;
  localparam logic [2:0] BIO_T4 = 3'h3;
  localparam logic [2:0] BIO_T5 = 3'h4;
  localparam logic [2:0] BIO_T6 = 3'h5;
  localparam logic [5:0] BIO_REG_CTRL = 6'h00;
  localparam logic [5:0] BIO_REG_STATUS = 6'h04;
  localparam logic [5:0] BIO_REG_COUNT = 6'h08;
  localparam logic [5:0] BIO_REG_BUFADDR = 6'h0c;
  localparam logic [5:0] BIO_REG_MEMADDR = 6'h10;
  localparam logic [5:0] BIO_REG_MEMDATA = 6'h14;
  localparam int BIO_CTRL_START = 0;
  localparam int BIO_CTRL_DIR = 1;
  localparam int BIO_CTRL_SETCTL = 2;
  localparam int BIO_CTRL_CLRCTL = 3;
  localparam int BIO_CTRL_ABORT = 4;
  localparam logic [1:0] BIO_RESP_OKAY = 2'h0;
  localparam logic [1:0] BIO_RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    BIO_IDLE = 3'h0,
    BIO_TEST = 3'h1,
    BIO_XFER = 3'h3,
    BIO_STORE = 3'h2,
    BIO_NEXT = 3'h6,
    BIO_DONE = 3'h7,
    BIO_ABORT = 3'h5
  } bio_state_t;
endpackage : bio_pkg

// *** bio_tb_top.sv ***
// Self-checking bench for the computer end joined to an input card.
`timescale 1ns/1ps
module bio_tb_top import bio_pkg::*; ;
  typedef struct packed {logic [5:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} bio_row_t;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [5:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd_d, st;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, ien, p_start, ctl, aw_t, w_t, fin;
  logic [1:0] bresp, rresp, wr_r, rd_r;
  logic emerg = 1'h0, freeze = 1'h0, p_ready = 1'h0, go = 1'h0;
  logic [15:0] p_data = '0, p_out;
  int mismatches = 0, n_compared = 0, sent = 0, target = 0, starts = 0, dly = 0, base, i, c, s0;
  bio_row_t rows [9] = '{'{BIO_REG_COUNT, 32'h5, 32'h5, BIO_RESP_OKAY},
    '{BIO_REG_COUNT, 32'h300, 32'h100, BIO_RESP_OKAY}, '{BIO_REG_BUFADDR, 32'h3c, 32'h3c, BIO_RESP_OKAY},
    '{BIO_REG_MEMADDR, 32'h7, 32'h7, BIO_RESP_OKAY}, '{BIO_REG_MEMDATA, 32'hbeef, 32'hbeef, BIO_RESP_OKAY},
    '{BIO_REG_CTRL, 32'h2, 32'h2, BIO_RESP_OKAY}, '{BIO_REG_CTRL, 32'h0, 32'h0, BIO_RESP_OKAY},
    '{6'h18, 32'h1, 32'h0, BIO_RESP_SLVERR}, '{6'h3c, 32'h1, 32'h0, BIO_RESP_SLVERR}};
  always #12.5 aclk = ~aclk;
  bio_bus_if #(.DW(16)) bus ();
  bio_cpu #(.HANG_CYCLES(50)) i_bio_cpu (.aclk(aclk), .aresetn(aresetn), .bus(bus), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .emergency_interrupt_condition(emerg), .dma_freeze(freeze), .interrupts_enabled(ien));
  bio_card #(.OUTPUT_CARD(1'b0)) i_bio_card (.aclk(aclk), .aresetn(aresetn), .bus(bus), .periph_ready(p_ready),
    .periph_data_in(p_data), .periph_start(p_start), .periph_data_out(p_out), .control_active(ctl));
  bio_assertions #(.DW(16)) i_bio_assertions (.aclk(aclk), .aresetn(aresetn), .io_bus_cpu_o(bus.io_bus_cpu_o),
    .io_bus_cpu_oe(bus.io_bus_cpu_oe), .io_bus_card_o(bus.io_bus_card_o), .io_bus_card_oe(bus.io_bus_card_oe),
    .io_bus_i(bus.io_bus_i), .set_control_instruction(bus.set_control_instruction),
    .clear_control(bus.clear_control), .block_strobe_qualifier(bus.block_strobe_qualifier),
    .block_input_strobe(bus.block_input_strobe), .block_output_strobe(bus.block_output_strobe),
    .skip_on_flag_line(bus.skip_on_flag_line));
  // Far-side peripheral: a start or a kick leads to the next word four cycles later.
  always @(posedge aclk) begin
    if (p_start || go) begin
      starts <= starts + (p_start ? 1 : 0);
      dly <= 4;
      p_ready <= 1'h0;
    end else begin
      dly <= (dly > 0) ? dly - 1 : 0;
      p_ready <= (dly == 1 && sent < target);
      if (dly == 1 && sent < target) begin
        p_data <= 16'ha500 + 16'(sent);
        sent <= sent + 1;
      end
    end
  end
  task wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task give_up;
    mismatches++;
    $display("BAD wait expected answer seen none");
    wrap_up();
  endtask : give_up
  task wr(input logic [5:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    fin = 1'h0;
    for (int k = 0; k < 100 && !fin; k++) begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      fin = bvalid;
      wr_r = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'h0;
      if (w_t) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    @(posedge aclk);
    if (!fin) give_up();
  endtask : wr
  task rd(input logic [5:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    fin = 1'h0;
    for (int k = 0; k < 100 && !fin; k++) begin
      @(negedge aclk);
      aw_t = arvalid && arready;
      fin = rvalid;
      rd_d = rdata;
      rd_r = rresp;
      @(posedge aclk);
      if (aw_t) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    @(posedge aclk);
    if (!fin) give_up();
  endtask : rd
  task wait_st(input logic [31:0] mask, input logic [31:0] val);
    int k;
    for (k = 0; k < 300; k++) begin
      rd(BIO_REG_STATUS);
      st = rd_d & mask;
      if (st === val) break;
    end
    if (k == 300) give_up();
  endtask : wait_st
  task kick;
    go <= 1'h1;
    @(posedge aclk);
    go <= 1'h0;
  endtask : kick
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    cmp("ien", 32'h1, 32'(ien));
    rd(BIO_REG_STATUS);
    cmp("status", 32'h8, rd_d);
    foreach (rows[r]) begin
      wr(rows[r].a, rows[r].d);
      cmp("bresp", 32'(rows[r].r), 32'(wr_r));
      rd(rows[r].a);
      cmp("rdata", rows[r].e, rd_d);
      cmp("rresp", 32'(rows[r].r), 32'(rd_r));
    end
    $display("test registers done");
    wr(BIO_REG_CTRL, 32'h4);
    rd(BIO_REG_STATUS);
    cmp("control", 32'h1, 32'(ctl));
    base = sent;
    s0 = starts;
    target = sent + 3;
    freeze <= 1'h1;
    kick();
    wr(BIO_REG_COUNT, 32'h3);
    wr(BIO_REG_BUFADDR, 32'h10);
    wr(BIO_REG_CTRL, 32'h1);
    repeat (30) @(posedge aclk);
    rd(BIO_REG_COUNT);
    cmp("frozen count", 32'h3, rd_d);
    cmp("ien busy", 32'h0, 32'(ien));
    freeze <= 1'h0;
    wait_st(32'h3, 32'h2);
    cmp("ien end", 32'h1, 32'(ien));
    rd(BIO_REG_COUNT);
    cmp("count", 32'h0, rd_d);
    cmp("acks", 32'(s0 + 3), 32'(starts));
    for (i = 0; i < 3; i++) begin
      wr(BIO_REG_MEMADDR, 32'h10 + 32'(i));
      rd(BIO_REG_MEMDATA);
      cmp("word", 32'(16'ha500 + 16'(base + i)), rd_d);
    end
    $display("test input block done");
    for (c = 0; c < 3; c++) begin
      wr(BIO_REG_COUNT, 32'h2);
      wr(BIO_REG_CTRL, 32'h1);
      if (c == 0) emerg <= 1'h1;
      if (c == 1) wr(BIO_REG_CTRL, 32'h10);
      wait_st(32'h7, 32'h4);
      cmp("abort", 32'h4, st);
      cmp("ien abort", 32'h1, 32'(ien));
      emerg <= 1'h0;
      rd(BIO_REG_COUNT);
      cmp("abort count", 32'h2, rd_d);
    end
    $display("test aborts done");
    wr(BIO_REG_COUNT, 32'h0);
    wr(BIO_REG_CTRL, 32'h1);
    wait_st(32'h7, 32'h2);
    cmp("empty block", 32'h2, st);
    target = sent + 1;
    kick();
    wr(BIO_REG_COUNT, 32'h1);
    wr(BIO_REG_CTRL, 32'h3);
    wait_st(32'h3, 32'h2);
    cmp("output block", 32'h2, st);
    cmp("periph out", 32'h0, 32'(p_out));
    wr(BIO_REG_CTRL, 32'h8);
    rd(BIO_REG_STATUS);
    cmp("control off", 32'h0, 32'(ctl));
    $display("test blocks done");
    wr(BIO_REG_CTRL, 32'h4);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    cmp("ien reset", 32'h1, 32'(ien));
    cmp("control reset", 32'h0, 32'(ctl));
    rd(BIO_REG_STATUS);
    cmp("status reset", 32'h8, rd_d);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule : bio_tb_top
